// ### shared/ers_pkg.sv
// Shared constants and types of the serial EEPROM read sequencer.
package ers_pkg;

   // ---------------------------------------------------------------
   // Control byte layout
   // ---------------------------------------------------------------
   localparam logic [3:0] DEV_CODE     = 4'ha;   // Fixed device-type code.
   localparam int         DEV_CODE_LSB = 4;      // Lowest bit of the code.
   localparam int         CS_LSB       = 1;      // Lowest chip-select bit.
   localparam int         RW_BIT       = 0;      // Direction flag position.

   // ---------------------------------------------------------------
   // Widths, depths and reset values
   // ---------------------------------------------------------------
   localparam int         DATA_W       = 8;      // Width of a data byte.
   localparam int         PTR_W        = 7;      // Address pointer width.
   localparam int         FIFO_DEPTH   = 8;      // Words in the data FIFO.
   localparam logic [6:0] PTR_RESET    = 7'h00;  // Pointer after reset.
   localparam logic [2:0] BIT_LAST     = 3'h7;   // Index of the last bit.

   // ---------------------------------------------------------------
   // Sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CTRL,
      ST_ACK_C,
      ST_ADDR,
      ST_ACK_A,
      ST_LOAD,
      ST_SEND,
      ST_MACK
   } ers_state_type;

   typedef struct packed {
      logic          scl_s1;
      logic          scl_s2;
      logic          scl_d;
      logic          sda_s1;
      logic          sda_s2;
      logic          sda_d;
      logic [2:0]    cs_s1;
      logic [2:0]    cs_s2;
      ers_state_type state;
      logic [2:0]    cnt;
      logic          byte_done;
      logic [7:0]    shift;
      logic [6:0]    ptr;
      logic          rw;
      logic          more;
      logic          sda_oe;
      logic          scl_oe;
      logic          mem_req;
   } ers_regs_type;

endpackage : ers_pkg

// ### rtl/ers_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module ers_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input  wire logic         clk,        // System clock.
   input  wire logic         srst,       // Synchronous reset, high.
   input  wire logic         flush,      // Empties the FIFO.
   input  wire logic         in_valid,   // Word offered.
   output      logic         in_ready,   // Room for a word.
   input  wire logic [W-1:0] in_data,    // Word to store.
   output      logic         out_valid,  // Word available.
   input  wire logic         out_ready,  // Word taken.
   output      logic [W-1:0] out_data    // Oldest word.
);

   localparam int AW = (D > 1) ? $clog2(D) : 1;

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0]         wp;
      logic [AW:0]         rp;
   } ers_fifo_state_type;

   ers_fifo_state_type r_reg;
   ers_fifo_state_type r_next;

   // ---------------------------------------------------------------
   // Status
   // ---------------------------------------------------------------
   // Full when the pointers differ only in their wrap bit.
   assign out_valid = (r_reg.wp != r_reg.rp);
   assign in_ready  = (r_reg.wp[AW-1:0] != r_reg.rp[AW-1:0]) ||
                      (r_reg.wp[AW] == r_reg.rp[AW]);
   assign out_data  = r_reg.mem[r_reg.rp[AW-1:0]];

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   // Pointers run over twice the depth, so D must be a power of two.
   always_comb begin
      r_next = r_reg;
      if (flush) begin
         r_next.rp = r_reg.wp;
      end else begin
         if (in_valid && in_ready) begin
            r_next.mem[r_reg.wp[AW-1:0]] = in_data;
            r_next.wp = r_reg.wp + 1'b1;
         end
         if (out_valid && out_ready) begin
            r_next.rp = r_reg.rp + 1'b1;
         end
      end
   end

   // Registers the state; reset empties the FIFO.
   always_ff @(posedge clk) begin
      if (srst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

endmodule : ers_fifo

// ### rtl/ers_read_seq.sv
// Read sequencer of a two-wire serial EEPROM slave.
// Function
// - Repeated START abandons the write, keeps the loaded pointer.
// - Read control byte is acknowledged, then the byte at pointer sent.
// - Master not acknowledging ends the read; data line is released.
// - After a read the pointer names the byte after the last sent.
// - Each master acknowledge makes the next sequential byte go out.
// - Pointer increments by one after each delivered byte.
// - Pointer wraps from the top location to the first.
// - Control byte accepted only with device code and matching selects.
// - Low bit of the control byte selects read or write.
// - No acknowledge while a programming cycle runs.
`timescale 1ns/10ps
module ers_read_seq (
   input  wire logic       CLK_SYS,           // System clock, 20 MHz.
   input  wire logic       SRST,              // Synchronous reset, high.
   input  wire logic       SCL_IN,            // Serial clock line level.
   output      logic       SCL_OUT,           // Serial clock drive value.
   output      logic       SCL_OE,            // Holds the clock line low.
   input  wire logic       SDA_IN,            // Serial data line level.
   output      logic       SDA_OUT,           // Serial data drive value.
   output      logic       SDA_OE,            // Pulls the data line low.
   input  wire logic       CHIP_SELECT_BIT0,  // Chip-select strap 0.
   input  wire logic       CHIP_SELECT_BIT1,  // Chip-select strap 1.
   input  wire logic       CHIP_SELECT_BIT2,  // Chip-select strap 2.
   input  wire logic       PROG_BUSY,         // Programming cycle running.
   output      logic       MEM_REQ,           // Read request pulse.
   output      logic [6:0] MEM_ADDR,          // Address of the request.
   input  wire logic       MEM_RVALID,        // Read data offered.
   output      logic       MEM_RREADY,        // FIFO can take read data.
   input  wire logic [7:0] MEM_RDATA          // Read data byte.
);

   // ---------------------------------------------------------------
   // State and helpers
   // ---------------------------------------------------------------
   ers_pkg::ers_regs_type r_reg;
   ers_pkg::ers_regs_type r_next;

   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic       fifo_valid;
   logic       fifo_ready;
   logic [7:0] fifo_data;

   // True when the byte carries the device code and our chip selects.
   function automatic logic ctrl_match(input logic [7:0] b,
                                       input logic [2:0] cs);
      ctrl_match = (b[7:ers_pkg::DEV_CODE_LSB] == ers_pkg::DEV_CODE) &&
                   (b[ers_pkg::DEV_CODE_LSB-1:ers_pkg::CS_LSB] == cs);
   endfunction : ctrl_match

   // Edges and bus conditions, seen on the synchronised lines only.
   assign scl_rise  = r_reg.scl_s2 && !r_reg.scl_d;
   assign scl_fall  = !r_reg.scl_s2 && r_reg.scl_d;
   assign start_det = r_reg.scl_s2 && r_reg.scl_d &&
                      r_reg.sda_d && !r_reg.sda_s2;
   assign stop_det  = r_reg.scl_s2 && r_reg.scl_d &&
                      !r_reg.sda_d && r_reg.sda_s2;

   // The shifter drains the FIFO only while it waits for a byte.
   assign fifo_ready = (r_reg.state == ers_pkg::ST_LOAD);

   // ---------------------------------------------------------------
   // Read data FIFO
   // ---------------------------------------------------------------
   ers_fifo #(
      .W (ers_pkg::DATA_W),
      .D (ers_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (CLK_SYS),
      .srst      (SRST),
      .flush     (start_det),
      .in_valid  (MEM_RVALID),
      .in_ready  (MEM_RREADY),
      .in_data   (MEM_RDATA),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready),
      .out_data  (fifo_data)
   );

   // ---------------------------------------------------------------
   // Sequencer next state
   // ---------------------------------------------------------------
   // START and STOP override every state; bytes move on clock edges.
   always_comb begin
      r_next         = r_reg;
      r_next.mem_req = 1'b0;
      r_next.scl_s1  = SCL_IN;
      r_next.scl_s2  = r_reg.scl_s1;
      r_next.scl_d   = r_reg.scl_s2;
      r_next.sda_s1  = SDA_IN;
      r_next.sda_s2  = r_reg.sda_s1;
      r_next.sda_d   = r_reg.sda_s2;
      r_next.cs_s1   = {CHIP_SELECT_BIT2, CHIP_SELECT_BIT1,
                        CHIP_SELECT_BIT0};
      r_next.cs_s2   = r_reg.cs_s1;
      if (start_det) begin
         // A repeated START drops any write, the pointer stays.
         r_next.state     = ers_pkg::ST_CTRL;
         r_next.cnt       = '0;
         r_next.byte_done = 1'b0;
         r_next.sda_oe    = 1'b0;
         r_next.scl_oe    = 1'b0;
      end else if (stop_det) begin
         r_next.state     = ers_pkg::ST_IDLE;
         r_next.sda_oe    = 1'b0;
         r_next.scl_oe    = 1'b0;
      end else begin
         case (r_reg.state)
            ers_pkg::ST_IDLE: begin
               r_next.sda_oe = 1'b0;
            end
            ers_pkg::ST_CTRL, ers_pkg::ST_ADDR: begin
               if (scl_rise && !r_reg.byte_done) begin
                  r_next.shift = {r_reg.shift[6:0], r_reg.sda_s2};
                  r_next.cnt   = r_reg.cnt + 3'h1;
                  if (r_reg.cnt == ers_pkg::BIT_LAST) begin
                     r_next.byte_done = 1'b1;
                  end
               end
               if (scl_fall && r_reg.byte_done) begin
                  r_next.byte_done = 1'b0;
                  r_next.cnt       = '0;
                  if (PROG_BUSY) begin
                     r_next.state = ers_pkg::ST_IDLE;
                  end else if (r_reg.state == ers_pkg::ST_ADDR) begin
                     // Word address after a write control byte.
                     r_next.ptr    = r_reg.shift[6:0];
                     r_next.sda_oe = 1'b1;
                     r_next.state  = ers_pkg::ST_ACK_A;
                  end else if (ctrl_match(r_reg.shift, r_reg.cs_s2)) begin
                     r_next.sda_oe  = 1'b1;
                     r_next.rw      = r_reg.shift[ers_pkg::RW_BIT];
                     r_next.mem_req = r_reg.shift[ers_pkg::RW_BIT];
                     r_next.state   = ers_pkg::ST_ACK_C;
                  end else begin
                     r_next.state = ers_pkg::ST_IDLE;
                  end
               end
            end
            ers_pkg::ST_ACK_C: begin
               if (scl_fall) begin
                  r_next.sda_oe = 1'b0;
                  if (r_reg.rw) begin
                     r_next.state  = ers_pkg::ST_LOAD;
                     r_next.scl_oe = 1'b1;
                  end else begin
                     r_next.state = ers_pkg::ST_ADDR;
                  end
               end
            end
            ers_pkg::ST_ACK_A: begin
               // Write data is not taken; wait for the next START.
               if (scl_fall) begin
                  r_next.sda_oe = 1'b0;
                  r_next.state  = ers_pkg::ST_IDLE;
               end
            end
            ers_pkg::ST_LOAD: begin
               // Stretch the clock low until the byte has arrived, and one
               // cycle more so the first bit is set up before SCL rises.
               r_next.scl_oe = 1'b1;
               if (fifo_valid) begin
                  r_next.shift  = fifo_data;
                  r_next.sda_oe = !fifo_data[7];
                  r_next.cnt    = '0;
                  r_next.state  = ers_pkg::ST_SEND;
               end
            end
            ers_pkg::ST_SEND: begin
               r_next.scl_oe = 1'b0;
               if (scl_fall) begin
                  if (r_reg.cnt == ers_pkg::BIT_LAST) begin
                     r_next.sda_oe = 1'b0;
                     // Seven-bit add wraps the top location to zero.
                     r_next.ptr    = r_reg.ptr + 7'h01;
                     r_next.more   = 1'b0;
                     r_next.state  = ers_pkg::ST_MACK;
                  end else begin
                     r_next.shift  = {r_reg.shift[6:0], 1'b0};
                     r_next.sda_oe = !r_reg.shift[6];
                     r_next.cnt    = r_reg.cnt + 3'h1;
                  end
               end
            end
            ers_pkg::ST_MACK: begin
               if (scl_rise) begin
                  r_next.more    = !r_reg.sda_s2;
                  r_next.mem_req = !r_reg.sda_s2;
               end
               if (scl_fall) begin
                  if (r_reg.more) begin
                     r_next.state  = ers_pkg::ST_LOAD;
                     r_next.scl_oe = 1'b1;
                  end else begin
                     r_next.state  = ers_pkg::ST_IDLE;
                     r_next.sda_oe = 1'b0;
                  end
               end
            end
            default: begin
               r_next.state  = ers_pkg::ST_IDLE;
               r_next.sda_oe = 1'b0;
               r_next.scl_oe = 1'b0;
            end
         endcase
      end
   end

   // Registers the whole state; lines idle high after reset.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         r_reg        <= '0;
         r_reg.scl_s1 <= 1'b1;
         r_reg.scl_s2 <= 1'b1;
         r_reg.scl_d  <= 1'b1;
         r_reg.sda_s1 <= 1'b1;
         r_reg.sda_s2 <= 1'b1;
         r_reg.sda_d  <= 1'b1;
         r_reg.ptr    <= ers_pkg::PTR_RESET;
         r_reg.state  <= ers_pkg::ST_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Both lines are open drain: only a low level is ever driven.
   assign SCL_OUT  = 1'b0;
   assign SDA_OUT  = 1'b0;
   assign SCL_OE   = r_reg.scl_oe;
   assign SDA_OE   = r_reg.sda_oe;
   assign MEM_REQ  = r_reg.mem_req;
   assign MEM_ADDR = r_reg.ptr;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (SRST);

   // A matching control byte is acknowledged on the next fall.
   a_ctrl_ack_match: assert property (
      (r_reg.state == ers_pkg::ST_CTRL) && scl_fall && r_reg.byte_done &&
      !start_det && !stop_det && !PROG_BUSY &&
      ctrl_match(r_reg.shift, r_reg.cs_s2)
      |=> (r_reg.state == ers_pkg::ST_ACK_C) && SDA_OE)
      else $error("Matching control byte not acknowledged.");

   // A foreign control byte sends the sequencer back to idle.
   a_ctrl_reject: assert property (
      (r_reg.state == ers_pkg::ST_CTRL) && scl_fall && r_reg.byte_done &&
      !start_det && !stop_det && !ctrl_match(r_reg.shift, r_reg.cs_s2)
      |=> (r_reg.state == ers_pkg::ST_IDLE) && !SDA_OE)
      else $error("Unmatched control byte was not ignored.");

   // No acknowledge at all while programming is in progress.
   a_busy_no_ack: assert property (
      PROG_BUSY && r_reg.byte_done && scl_fall && !start_det &&
      ((r_reg.state == ers_pkg::ST_CTRL) ||
       (r_reg.state == ers_pkg::ST_ADDR))
      |=> !SDA_OE [*2])
      else $error("Byte acknowledged during programming.");

   // The word address loads the pointer without its top bit.
   a_addr_load: assert property (
      (r_reg.state == ers_pkg::ST_ADDR) && scl_fall && r_reg.byte_done &&
      !start_det && !stop_det && !PROG_BUSY
      |=> MEM_ADDR == $past(r_reg.shift[6:0]))
      else $error("Word address not loaded into the pointer.");

   // A repeated START keeps the pointer and waits for a control byte.
   a_start_keeps: assert property (
      start_det |=> (r_reg.state == ers_pkg::ST_CTRL) &&
                    $stable(MEM_ADDR) && !SDA_OE)
      else $error("Repeated START lost the pointer.");

   // The direction flag picks the read path after the acknowledge.
   a_rw_select: assert property (
      (r_reg.state == ers_pkg::ST_ACK_C) && scl_fall && !start_det &&
      !stop_det
      |=> (r_reg.state == (r_reg.rw ? ers_pkg::ST_LOAD
                                    : ers_pkg::ST_ADDR)))
      else $error("Direction flag ignored.");

   // A read acknowledge requests the byte at the pointer at once.
   a_read_fetch: assert property (
      $rose(r_reg.state == ers_pkg::ST_ACK_C) && r_reg.rw
      |-> MEM_REQ && SDA_OE)
      else $error("Read control byte gave no data request.");

   // The pointer steps by one, wrapping, after each sent byte.
   a_ptr_step: assert property (
      (r_reg.state == ers_pkg::ST_SEND) && scl_fall &&
      (r_reg.cnt == ers_pkg::BIT_LAST) && !start_det && !stop_det
      |=> (MEM_ADDR == $past(MEM_ADDR) + 7'h01) &&
          (r_reg.state == ers_pkg::ST_MACK) && !SDA_OE)
      else $error("Pointer did not advance after a byte.");

   // From the top location the pointer returns to zero.
   a_ptr_wrap: assert property (
      (r_reg.state == ers_pkg::ST_SEND) && scl_fall &&
      (r_reg.cnt == ers_pkg::BIT_LAST) && (MEM_ADDR == 7'h7f) &&
      !start_det && !stop_det
      |=> MEM_ADDR == 7'h00)
      else $error("Pointer did not wrap.");

   // A master acknowledge fetches and loads the next byte.
   a_ack_next: assert property (
      (r_reg.state == ers_pkg::ST_MACK) && scl_fall && r_reg.more &&
      !start_det && !stop_det
      |=> (r_reg.state == ers_pkg::ST_LOAD) && SCL_OE)
      else $error("Master acknowledge did not continue the read.");

   // A missing master acknowledge ends the read and frees the line.
   a_nack_release: assert property (
      (r_reg.state == ers_pkg::ST_MACK) && scl_fall && !r_reg.more &&
      !start_det && !stop_det
      |=> (r_reg.state == ers_pkg::ST_IDLE) && !SDA_OE && !SCL_OE)
      else $error("Read not ended after no acknowledge.");

   // STOP always returns to idle with both lines released.
   a_stop_idle: assert property (
      stop_det && !start_det
      |=> (r_reg.state == ers_pkg::ST_IDLE) && !SDA_OE && !SCL_OE)
      else $error("STOP did not return to idle.");

endmodule : ers_read_seq

// ### bench/ers_bus_master.sv
// Two-wire bus master model that drives the serial clock and data lines.
`timescale 1ns/10ps
module ers_bus_master (
   input  wire logic clk,      // System clock, paces the model.
   input  wire logic scl_w,    // Resolved clock line level.
   input  wire logic sda_w,    // Resolved data line level.
   output      logic scl_drv,  // Master clock level, high releases.
   output      logic sda_drv   // Master data level, high releases.
);
   // Both lines are released while the bus is not busy.
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end

   // Waits a number of system cycles.
   task automatic gap(input int n);
      repeat (n) @(negedge clk);
   endtask : gap

   // START from idle, or a repeated START from a low clock.
   task automatic start();
      sda_drv = 1'b1;
      gap(3);
      scl_drv = 1'b1;
      gap(5);
      sda_drv = 1'b0;
      gap(5);
      scl_drv = 1'b0;
      gap(1);
   endtask : start

   // STOP: data rises while the clock is high.
   task automatic stop();
      sda_drv = 1'b0;
      gap(3);
      scl_drv = 1'b1;
      gap(5);
      sda_drv = 1'b1;
      gap(5);
   endtask : stop

   // One 400 ns clock pulse; waits out a clock stretch by the slave of up to 4000 cycles.
   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      gap(3);
      scl_drv = 1'b1;
      gap(1);
      for (int i = 0; i < 4000 && scl_w !== 1'b1; i++) @(negedge clk);
      gap(3);
      r = sda_w;
      scl_drv = 1'b0;
      gap(1);
   endtask : bit_io

   // Sends a byte MSB first and returns whether the slave acknowledged.
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask : wr_byte

   // Reads a byte, then acknowledges it or withholds the acknowledge.
   task automatic rd_byte(input logic ack_m, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(~ack_m, r);
   endtask : rd_byte
endmodule : ers_bus_master

// ### bench/testbench.sv
// Self-checking testbench of the serial EEPROM read sequencer.
`timescale 1ns/10ps
module testbench;
   logic       clk_sys, srst, prog_busy, mem_rvalid, m_scl, m_sda;
   logic       scl_oe, sda_oe, mem_req, mem_rready, scl_out, sda_out;
   logic [6:0] mem_addr, req_addr;
   logic [7:0] mem_rdata;
   logic [2:0] cs;
   int         n_mismatch, num_checks, mem_lat, lat_cnt;
   wire        scl_w = (scl_oe ? scl_out : 1'b1) & m_scl;
   wire        sda_w = (sda_oe ? sda_out : 1'b1) & m_sda;

   ers_read_seq ers_read_seq_inst (.CLK_SYS(clk_sys), .SRST(srst),
      .SCL_IN(scl_w), .SCL_OUT(scl_out), .SCL_OE(scl_oe), .SDA_IN(sda_w),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .CHIP_SELECT_BIT0(cs[0]),
      .CHIP_SELECT_BIT1(cs[1]), .CHIP_SELECT_BIT2(cs[2]),
      .PROG_BUSY(prog_busy), .MEM_REQ(mem_req), .MEM_ADDR(mem_addr),
      .MEM_RVALID(mem_rvalid), .MEM_RREADY(mem_rready),
      .MEM_RDATA(mem_rdata));
   ers_bus_master master_inst (.clk(clk_sys), .scl_w(scl_w),
      .sda_w(sda_w), .scl_drv(m_scl), .sda_drv(m_sda));

   // System clock of 50 ns.
   always #25 clk_sys = ~clk_sys;

   // Memory array content, distinct for every address.
   function automatic logic [7:0] mem_byte(input logic [6:0] a);
      return {a, ~a[0]} ^ 8'h5a;
   endfunction : mem_byte

   // Memory model: answers a request mem_lat + 1 cycles after it.
   always @(negedge clk_sys) begin
      if (mem_req !== 1'b1 && lat_cnt == 0 && mem_rready === 1'b1) begin
         mem_rvalid <= 1'b1;
         mem_rdata <= mem_byte(req_addr);
         lat_cnt <= -1;
      end else begin
         mem_rvalid <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req === 1'b1) begin
            req_addr <= mem_addr;
            lat_cnt <= mem_lat;
         end else if (lat_cnt > 0) begin
            lat_cnt <= lat_cnt - 1;
         end
      end
   end

   // Compares a seen value with the expected one.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test

   // Sends one control byte after a START and checks the acknowledge.
   task automatic ctrl(input logic [3:0] code, input logic [2:0] sel,
                       input logic rw, input logic exp_ack);
      logic ack;
      master_inst.start();
      master_inst.wr_byte({code, sel, rw}, ack);
      chk(8'(ack), 8'(exp_ack));
   endtask : ctrl

   // Dummy write that loads the word address.
   task automatic set_ptr(input logic [7:0] a);
      logic ack;
      ctrl(ers_pkg::DEV_CODE, cs, 1'b0, 1'b1);
      master_inst.wr_byte(a, ack);
      chk(8'(ack), 8'h01);
   endtask : set_ptr

   // Read of n bytes from address a, ended by a withheld acknowledge.
   task automatic rd_run(input logic [6:0] a, input int n);
      logic [7:0] d;
      ctrl(ers_pkg::DEV_CODE, cs, 1'b1, 1'b1);
      for (int i = 0; i < n; i++) begin
         master_inst.rd_byte(i < n - 1, d);
         chk(d, mem_byte(7'(a + 7'(i))));
      end
      master_inst.rd_byte(1'b0, d);
      chk(d, 8'hff);
      master_inst.stop();
   endtask : rd_run

   // Random read with the top address bit set, then a two-byte current read.
   task automatic t_random();
      set_ptr(8'h85);
      rd_run(7'h05, 1);
      rd_run(7'h06, 2);
   endtask : t_random

   // Sequential read across the top address on a slow memory.
   task automatic t_wrap();
      mem_lat = 30;
      set_ptr(8'h7e);
      rd_run(7'h7e, 4);
      mem_lat = 1;
      rd_run(7'h02, 1);
   endtask : t_wrap

   // Refused control bytes and write data leave the pointer alone.
   task automatic t_refuse();
      logic ack;
      ctrl(4'hb, cs, 1'b1, 1'b0);
      master_inst.stop();
      ctrl(ers_pkg::DEV_CODE, cs ^ 3'h1, 1'b1, 1'b0);
      master_inst.stop();
      prog_busy = 1'b1;
      ctrl(ers_pkg::DEV_CODE, cs, 1'b1, 1'b0);
      master_inst.stop();
      prog_busy = 1'b0;
      rd_run(7'h03, 1);
      set_ptr(8'h10);
      master_inst.wr_byte(8'h55, ack);
      chk(8'(ack), 8'h00);
      master_inst.stop();
      rd_run(7'h10, 1);
   endtask : t_refuse

   // Watchdog that cuts a hang short.
   initial begin
      #3000000;
      n_mismatch++;
      end_of_test();
   end

   // Main sequence.
   initial begin
      clk_sys = 1'b0;
      srst = 1'b1;
      prog_busy = 1'b0;
      mem_rvalid = 1'b0;
      mem_rdata = 8'h00;
      cs = 3'h5;
      mem_lat = 1;
      lat_cnt = -1;
      n_mismatch = 0;
      num_checks = 0;
      repeat (12) @(negedge clk_sys);
      srst = 1'b0;
      repeat (6) @(negedge clk_sys);
      t_random();
      t_wrap();
      t_refuse();
      end_of_test();
   end
endmodule : testbench
